// >>> dprc_fab_model.sv
// Fabric user logic model clocking requests into one RAM port
module dprc_fab_model import dprc_pkg::*; #(
  parameter int ADDR_W = dprc_pkg::DPRC_ADDR_W
) (
  // Clock
  input wire logic core_clk,
  // Request toward the block
  output logic fab_clk,
  output logic wr_sel,
  output logic rd_strobe,
  output logic [ADDR_W-1:0] addr,
  output logic [dprc_pkg::DPRC_LANES-1:0] lanes,
  output logic [dprc_pkg::DPRC_DATA_W-1:0] din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fab_clk = 1'h0;
    {wr_sel, rd_strobe, addr, lanes, din} = '0;
  end
  // One request per rise; random high phase gives prompt and slow cycles
  task automatic drive(logic w, logic rs, logic [ADDR_W-1:0] a,
                       logic [7:0] l, logic [71:0] d);
    int hi;
    hi = 2 + int'($urandom_range(4));
    @(posedge core_clk);
    #1;
    wr_sel = w;
    rd_strobe = rs;
    addr = a;
    lanes = l;
    din = d;
    @(posedge core_clk);
    #1;
    fab_clk = 1'h1;
    repeat (hi) @(posedge core_clk);
    #1;
    fab_clk = 1'h0;
    repeat (4) @(posedge core_clk);
    #1;
    // Released lines turn to garbage so stale values never pass
    {wr_sel, rd_strobe} = {~w, ~rs};
    addr = ~a;
    lanes = ~l;
    din = ~d;
  endtask
endmodule // dprc_fab_model

// >>> dprc_pkg.sv
// Shared constants and types of the dual-port RAM clocking block
// ============================================================
package dprc_pkg;
  // ============================================================
  // Geometry
  localparam int DPRC_DATA_W = 72;
  localparam int DPRC_LANES = 8;
  localparam int DPRC_LANE_W_PAR = 9;
  localparam int DPRC_LANE_W_NOPAR = 8;
  localparam int DPRC_ADDR_W = 13;
  // ============================================================
  // Reset values
  localparam logic [DPRC_DATA_W-1:0] DPRC_DATA_RST = 72'h0;
  localparam logic DPRC_CTRL_RST = 1'h0;
  // ============================================================
  // Clocking schemes
  typedef enum logic [1:0] {
    DPRC_MODE_INDEP,
    DPRC_MODE_INOUT,
    DPRC_MODE_RDWR
  } dprc_mode_e;
endpackage

// >>> dprc_port.sv
// Input, read-strobe and output registers of one RAM port
module dprc_port import dprc_pkg::*; #(
  parameter int DATA_W = dprc_pkg::DPRC_DATA_W,
  parameter int ADDR_W = dprc_pkg::DPRC_ADDR_W,
  parameter int LANES = dprc_pkg::DPRC_LANES
) (
  // Clock, reset, freeze
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Derived clock events, enables, clears
  input wire logic tick_in,
  input wire logic tick_out,
  input wire logic ce_in,
  input wire logic ce_out,
  input wire logic clr_in,
  input wire logic clr_out,
  // Configuration
  input wire logic use_rd_strobe,
  input wire logic wr_allow,
  input wire logic rd_allow,
  input wire logic out_reg_en,
  // Fabric side
  input wire logic wr_sel,
  input wire logic rd_strobe,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES-1:0] lanes,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout,
  // Array side
  output logic ram_wr,
  output logic ram_rd,
  output logic [ADDR_W-1:0] ram_addr,
  output logic [LANES-1:0] ram_lanes,
  output logic [DATA_W-1:0] ram_din,
  input wire logic [DATA_W-1:0] ram_q
);
  typedef struct packed {
    logic req;
    logic we;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lanes;
    logic [DATA_W-1:0] din;
    logic [DATA_W-1:0] dout;
  } dprc_port_s;
  dprc_port_s st_q, st_d;

  logic cap_in;
  logic cap_out;

  assign cap_in = tick_in && ce_in;
  assign cap_out = tick_out && ce_out;

  // ============================================================
  // Register update
  always_comb begin
    st_d = st_q;
    st_d.req = 1'b0;
    // Read strobe ignores the clear, only device reset touches it
    if (cap_in) begin
      st_d.rd = rd_strobe;
    end
    if (clr_in) begin
      st_d.we = DPRC_CTRL_RST;
      st_d.addr = '0;
      st_d.lanes = '0;
      st_d.din = DPRC_DATA_RST;
    end else if (cap_in) begin
      st_d.req = 1'b1;
      st_d.we = wr_sel;
      st_d.addr = addr;
      st_d.lanes = lanes;
      st_d.din = din;
    end
    if (clr_out) begin
      st_d.dout = DPRC_DATA_RST;
    end else if (cap_out) begin
      st_d.dout = ram_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // ============================================================
  // Array request, one cycle after capture
  assign ram_wr = st_q.req && st_q.we && wr_allow;
  assign ram_rd = st_q.req && rd_allow &&
                  (use_rd_strobe ? st_q.rd : !st_q.we);
  assign ram_addr = st_q.addr;
  assign ram_lanes = st_q.lanes;
  assign ram_din = st_q.din;
  // Bypass shows the array latch directly
  assign dout = out_reg_en ? st_q.dout : ram_q;
endmodule // dprc_port

// >>> dprc_ram.sv
// Storage array with two lane-masked ports
module dprc_ram import dprc_pkg::*; #(
  parameter int DATA_W = dprc_pkg::DPRC_DATA_W,
  parameter int ADDR_W = dprc_pkg::DPRC_ADDR_W,
  parameter int LANES = dprc_pkg::DPRC_LANES,
  parameter int LANE_W = dprc_pkg::DPRC_LANE_W_PAR
) (
  // Clock, reset, freeze
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Port A request
  input wire logic wr_a,
  input wire logic rd_a,
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic [LANES-1:0] lanes_a,
  input wire logic [DATA_W-1:0] din_a,
  // Port B request
  input wire logic wr_b,
  input wire logic rd_b,
  input wire logic [ADDR_W-1:0] addr_b,
  input wire logic [LANES-1:0] lanes_b,
  input wire logic [DATA_W-1:0] din_b,
  // Raw read data
  output logic [DATA_W-1:0] q_a,
  output logic [DATA_W-1:0] q_b
);
  localparam int DEPTH = 1 << ADDR_W;

  // No reset and no preload: contents start undefined
  logic [DATA_W-1:0] mem [DEPTH];

  typedef struct packed {
    logic [DATA_W-1:0] q_a;
    logic [DATA_W-1:0] q_b;
  } dprc_ram_s;
  dprc_ram_s st_q, st_d;

  // ============================================================
  // Array writes, port B last so it wins a same-address collision
  always_ff @(posedge core_clk) begin
    if (resetn && clk_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_a && lanes_a[i]) begin
          mem[addr_a][i*LANE_W +: LANE_W] <= din_a[i*LANE_W +: LANE_W];
        end
        if (wr_b && lanes_b[i]) begin
          mem[addr_b][i*LANE_W +: LANE_W] <= din_b[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ============================================================
  // Read latches hold until the next read on that port
  always_comb begin
    st_d = st_q;
    if (rd_a) begin
      st_d.q_a = mem[addr_a];
    end
    if (rd_b) begin
      st_d.q_b = mem[addr_b];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign q_a = st_q.q_a;
  assign q_b = st_q.q_b;
endmodule // dprc_ram

// >>> dprc_top.sv
// Dual-port RAM with selectable clocking schemes, fabric-facing top
module dprc_top import dprc_pkg::*; #(
  parameter int ADDR_W = dprc_pkg::DPRC_ADDR_W,
  parameter int LANE_W = dprc_pkg::DPRC_LANE_W_PAR
) (
  // Clock, reset, freeze
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Static configuration
  input wire dprc_pkg::dprc_mode_e ram_mode,
  input wire logic simple_dp,
  input wire logic in_clk_sel,
  input wire logic out_reg_en_a,
  input wire logic out_reg_en_b,
  // Fabric clocks, enables and clears
  input wire logic fab_clk_a,
  input wire logic fab_clk_b,
  input wire logic ce_in_a,
  input wire logic ce_out_a,
  input wire logic ce_in_b,
  input wire logic ce_out_b,
  input wire logic clr_in_a,
  input wire logic clr_out_a,
  input wire logic clr_in_b,
  input wire logic clr_out_b,
  // Port A fabric data
  input wire logic wr_sel_a,
  input wire logic [ADDR_W-1:0] addr_a,
  input wire logic [dprc_pkg::DPRC_LANES-1:0] lanes_a,
  input wire logic [dprc_pkg::DPRC_DATA_W-1:0] din_a,
  output logic [dprc_pkg::DPRC_DATA_W-1:0] dout_a,
  // Port B fabric data
  input wire logic wr_sel_b,
  input wire logic rd_strobe_b,
  input wire logic [ADDR_W-1:0] addr_b,
  input wire logic [dprc_pkg::DPRC_LANES-1:0] lanes_b,
  input wire logic [dprc_pkg::DPRC_DATA_W-1:0] din_b,
  output logic [dprc_pkg::DPRC_DATA_W-1:0] dout_b
);
  import dprc_pkg::*;

  localparam int DATA_W = DPRC_DATA_W;
  localparam int LANES = DPRC_LANES;

  // ============================================================
  // Elaboration checks
  if (LANE_W != DPRC_LANE_W_PAR && LANE_W != DPRC_LANE_W_NOPAR) begin : g_bad_lane
    $error("lane width must be 8 or 9");
  end
  if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr
    $error("address width out of range");
  end

  // ============================================================
  // Fabric pins, all sampled through two flip-flops
  typedef struct packed {
    logic clk_a;
    logic clk_b;
    logic ce_in_a;
    logic ce_out_a;
    logic ce_in_b;
    logic ce_out_b;
    logic clr_in_a;
    logic clr_out_a;
    logic clr_in_b;
    logic clr_out_b;
    logic wr_sel_a;
    logic wr_sel_b;
    logic rd_strobe_b;
    logic [ADDR_W-1:0] addr_a;
    logic [ADDR_W-1:0] addr_b;
    logic [LANES-1:0] lanes_a;
    logic [LANES-1:0] lanes_b;
    logic [DATA_W-1:0] din_a;
    logic [DATA_W-1:0] din_b;
  } dprc_pins_s;

  typedef struct packed {
    dprc_pins_s s1;
    dprc_pins_s s2;
    logic clk_a_prev;
    logic clk_b_prev;
  } dprc_top_s;

  dprc_pins_s pin_raw;
  dprc_pins_s pin;
  dprc_top_s st_q, st_d;

  // Data is delayed as much as the clocks, so capture stays aligned
  assign pin_raw = '{
    clk_a: fab_clk_a,
    clk_b: fab_clk_b,
    ce_in_a: ce_in_a,
    ce_out_a: ce_out_a,
    ce_in_b: ce_in_b,
    ce_out_b: ce_out_b,
    clr_in_a: clr_in_a,
    clr_out_a: clr_out_a,
    clr_in_b: clr_in_b,
    clr_out_b: clr_out_b,
    wr_sel_a: wr_sel_a,
    wr_sel_b: wr_sel_b,
    rd_strobe_b: rd_strobe_b,
    addr_a: addr_a,
    addr_b: addr_b,
    lanes_a: lanes_a,
    lanes_b: lanes_b,
    din_a: din_a,
    din_b: din_b
  };

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_raw;
    st_d.s2 = st_q.s1;
    st_d.clk_a_prev = st_q.s2.clk_a;
    st_d.clk_b_prev = st_q.s2.clk_b;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign pin = st_q.s2;

  // ============================================================
  // Clock events from the two fabric clocks
  logic tick_a;
  logic tick_b;

  assign tick_a = pin.clk_a && !st_q.clk_a_prev;
  assign tick_b = pin.clk_b && !st_q.clk_b_prev;

  // ============================================================
  // Scheme decode: which event, enable and clear steers each register
  logic a_tin, a_tout, a_cein, a_ceout, a_clrin, a_clrout;
  logic b_tin, b_tout, b_cein, b_ceout, b_clrin, b_clrout;
  logic is_simple;
  logic tick_inp;
  logic tick_outp;

  // One clock feeds every input register, the other the outputs
  assign tick_inp = in_clk_sel ? tick_b : tick_a;
  assign tick_outp = in_clk_sel ? tick_a : tick_b;

  always_comb begin
    a_tin = tick_a;
    a_tout = tick_a;
    a_cein = pin.ce_in_a;
    a_ceout = pin.ce_in_a;
    a_clrin = pin.clr_in_a;
    a_clrout = pin.clr_in_a;
    b_tin = tick_b;
    b_tout = tick_b;
    b_cein = pin.ce_in_b;
    b_ceout = pin.ce_in_b;
    b_clrin = pin.clr_in_b;
    b_clrout = pin.clr_in_b;
    is_simple = 1'b0;
    case (ram_mode)
      DPRC_MODE_INDEP: begin
        // Defaults: each port wholly on its own clock
        is_simple = 1'b0;
      end
      DPRC_MODE_INOUT: begin
        is_simple = simple_dp;
        a_tin = tick_inp;
        b_tin = tick_inp;
        a_tout = tick_outp;
        b_tout = tick_outp;
        a_ceout = pin.ce_out_a;
        b_ceout = pin.ce_out_b;
        a_clrout = pin.clr_out_a;
        b_clrout = pin.clr_out_b;
      end
      DPRC_MODE_RDWR: begin
        // Port A is the write side on clock A, port B reads on clock B
        is_simple = 1'b1;
        a_tin = tick_a;
        b_tin = tick_b;
        b_tout = tick_b;
        a_cein = pin.ce_in_a;
        b_cein = pin.ce_in_b;
        b_ceout = pin.ce_in_b;
        a_clrin = pin.clr_in_a;
        b_clrin = pin.clr_in_b;
        b_clrout = pin.clr_in_b;
      end
      default: begin
        is_simple = 1'b0;
      end
    endcase
  end

  // ============================================================
  // Ports and array
  logic wr_a, rd_a, wr_b, rd_b;
  logic [ADDR_W-1:0] ra_addr_a, ra_addr_b;
  logic [LANES-1:0] ra_lanes_a, ra_lanes_b;
  logic [DATA_W-1:0] ra_din_a, ra_din_b, q_a, q_b;

  // Simple dual-port: A only writes, B only reads under its strobe
  dprc_port #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) u_port_a (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .tick_in(a_tin),
    .tick_out(a_tout),
    .ce_in(a_cein),
    .ce_out(a_ceout && !is_simple),
    .clr_in(a_clrin),
    .clr_out(a_clrout && !is_simple),
    .use_rd_strobe(1'b0),
    .wr_allow(1'b1),
    .rd_allow(!is_simple),
    .out_reg_en(out_reg_en_a),
    .wr_sel(pin.wr_sel_a),
    .rd_strobe(1'b0),
    .addr(pin.addr_a),
    .lanes(pin.lanes_a),
    .din(pin.din_a),
    .dout(dout_a),
    .ram_wr(wr_a),
    .ram_rd(rd_a),
    .ram_addr(ra_addr_a),
    .ram_lanes(ra_lanes_a),
    .ram_din(ra_din_a),
    .ram_q(q_a)
  );

  dprc_port #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) u_port_b (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .tick_in(b_tin),
    .tick_out(b_tout),
    .ce_in(b_cein),
    .ce_out(b_ceout),
    .clr_in(b_clrin),
    .clr_out(b_clrout),
    .use_rd_strobe(is_simple),
    .wr_allow(!is_simple),
    .rd_allow(1'b1),
    .out_reg_en(out_reg_en_b),
    .wr_sel(pin.wr_sel_b),
    .rd_strobe(pin.rd_strobe_b),
    .addr(pin.addr_b),
    .lanes(pin.lanes_b),
    .din(pin.din_b),
    .dout(dout_b),
    .ram_wr(wr_b),
    .ram_rd(rd_b),
    .ram_addr(ra_addr_b),
    .ram_lanes(ra_lanes_b),
    .ram_din(ra_din_b),
    .ram_q(q_b)
  );

  // Narrow lanes leave the top data bits unwritten and reading as stored
  dprc_ram #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_ram (
    .core_clk(core_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .wr_a(wr_a),
    .rd_a(rd_a),
    .addr_a(ra_addr_a),
    .lanes_a(ra_lanes_a),
    .din_a(ra_din_a),
    .wr_b(wr_b),
    .rd_b(rd_b),
    .addr_b(ra_addr_b),
    .lanes_b(ra_lanes_b),
    .din_b(ra_din_b),
    .q_a(q_a),
    .q_b(q_b)
  );
endmodule // dprc_top

// >>> dprc_top_chk.sv
// Port-level assertion checker for the dual-port RAM top
module dprc_top_chk import dprc_pkg::*; (
  // Clock, reset, configuration
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire dprc_pkg::dprc_mode_e ram_mode,
  input wire logic out_reg_en_a,
  input wire logic out_reg_en_b,
  // Fabric controls
  input wire logic fab_clk_a,
  input wire logic fab_clk_b,
  input wire logic ce_in_a,
  input wire logic ce_in_b,
  input wire logic clr_in_a,
  input wire logic clr_in_b,
  // Read data
  input wire logic [dprc_pkg::DPRC_DATA_W-1:0] dout_a,
  input wire logic [dprc_pkg::DPRC_DATA_W-1:0] dout_b
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ============================================================
  // Helper counters; 20 marks a clear, whose effect is not timed
  logic pa_q, pb_q;
  logic [4:0] ca_q, cb_q;
  logic [3:0] cea_q, ceb_q, clrb_q, age_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      {pa_q, pb_q, cea_q, ceb_q, clrb_q, age_q} <= '0;
      ca_q <= 5'h14;
      cb_q <= 5'h14;
    end else if (clk_en) begin
      pa_q <= fab_clk_a;
      pb_q <= fab_clk_b;
      ca_q <= clr_in_a ? 5'h14 : (fab_clk_a && !pa_q) ? 5'h00 :
              (ca_q < 5'h13) ? ca_q + 5'h01 : ca_q;
      cb_q <= clr_in_b ? 5'h14 : (fab_clk_b && !pb_q) ? 5'h00 :
              (cb_q < 5'h13) ? cb_q + 5'h01 : cb_q;
      cea_q <= ce_in_a ? 4'h0 : (cea_q == 4'hF) ? cea_q : cea_q + 4'h1;
      ceb_q <= ce_in_b ? 4'h0 : (ceb_q == 4'hF) ? ceb_q : ceb_q + 4'h1;
      clrb_q <= !clr_in_b ? 4'h0 : (clrb_q == 4'hF) ? clrb_q : clrb_q + 4'h1;
      age_q <= (ram_mode != DPRC_MODE_RDWR) ? 4'h0 :
               (age_q == 4'hF) ? age_q : age_q + 4'h1;
    end
  end
  // ============================================================
  // Assertions
  property p_frz_a;
    !clk_en |=> $stable(dout_a);
  endproperty
  a_frz_a: assert property (p_frz_a)
    else $error("dout_a moved while frozen");
  property p_frz_b;
    !clk_en |=> $stable(dout_b);
  endproperty
  a_frz_b: assert property (p_frz_b)
    else $error("dout_b moved while frozen");
  property p_lat_a;
    ram_mode == DPRC_MODE_INDEP && $stable(ram_mode) &&
    $stable(out_reg_en_a) && $changed(dout_a) && ca_q < 5'h14
    |-> ca_q == (out_reg_en_a ? 5'h02 : 5'h03);
  endproperty
  a_lat_a: assert property (p_lat_a)
    else $error("dout_a changed off its port clock");
  property p_lat_b;
    ram_mode != DPRC_MODE_INOUT && $stable(ram_mode) &&
    $stable(out_reg_en_b) && $changed(dout_b) && cb_q < 5'h14
    |-> cb_q == (out_reg_en_b ? 5'h02 : 5'h03);
  endproperty
  a_lat_b: assert property (p_lat_b)
    else $error("dout_b changed off its port clock");
  property p_rdwr_a;
    age_q == 4'hF |-> $stable(dout_a);
  endproperty
  a_rdwr_a: assert property (p_rdwr_a)
    else $error("write side produced read data");
  property p_ce_a;
    ram_mode == DPRC_MODE_INDEP && !out_reg_en_a && cea_q > 4'h7
    |-> $stable(dout_a);
  endproperty
  a_ce_a: assert property (p_ce_a)
    else $error("dout_a read with enable low");
  property p_ce_b;
    ram_mode != DPRC_MODE_INOUT && !out_reg_en_b && ceb_q > 4'h7
    |-> $stable(dout_b);
  endproperty
  a_ce_b: assert property (p_ce_b)
    else $error("dout_b read with enable low");
  property p_clr_b;
    ram_mode == DPRC_MODE_RDWR && out_reg_en_b && clrb_q > 4'h4
    |-> dout_b == '0;
  endproperty
  a_clr_b: assert property (p_clr_b)
    else $error("read side clear left dout_b set");
endmodule // dprc_top_chk

bind dprc_top dprc_top_chk u_chk (.core_clk(core_clk), .resetn(resetn),
  .clk_en(clk_en), .ram_mode(ram_mode), .out_reg_en_a(out_reg_en_a),
  .out_reg_en_b(out_reg_en_b), .fab_clk_a(fab_clk_a),
  .fab_clk_b(fab_clk_b), .ce_in_a(ce_in_a), .ce_in_b(ce_in_b),
  .clr_in_a(clr_in_a), .clr_in_b(clr_in_b), .dout_a(dout_a),
  .dout_b(dout_b));

// >>> tb_top.sv
// Self-checking bench of the dual-port RAM top
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dprc_pkg::*;
  logic core_clk, resetn, clk_en, simple_dp, in_clk_sel;
  dprc_mode_e ram_mode;
  logic out_reg_en_a, out_reg_en_b, ce_in_a, ce_out_a, ce_in_b, ce_out_b;
  logic clr_in_a, clr_out_a, clr_in_b, clr_out_b, chk_a, chk_b;
  logic fab_clk_a, fab_clk_b, wr_sel_a, wr_sel_b, rd_strobe_b;
  logic [12:0] addr_a, addr_b;
  logic [7:0] lanes_a, lanes_b;
  logic [71:0] din_a, din_b, dout_a, dout_b;
  logic [71:0] mem [int];
  logic [71:0] qa [$], qb [$];
  int err_count, compares, cyc;
  dprc_fab_model pa (.core_clk, .fab_clk(fab_clk_a), .wr_sel(wr_sel_a),
    .rd_strobe(), .addr(addr_a), .lanes(lanes_a), .din(din_a));
  dprc_fab_model pb (.core_clk, .fab_clk(fab_clk_b), .wr_sel(wr_sel_b),
    .rd_strobe(rd_strobe_b), .addr(addr_b), .lanes(lanes_b), .din(din_b));
  dprc_top dut (.core_clk, .resetn, .clk_en, .ram_mode, .simple_dp,
    .in_clk_sel, .out_reg_en_a, .out_reg_en_b, .fab_clk_a, .fab_clk_b,
    .ce_in_a, .ce_out_a, .ce_in_b, .ce_out_b, .clr_in_a, .clr_out_a,
    .clr_in_b, .clr_out_b, .wr_sel_a, .addr_a, .lanes_a, .din_a, .dout_a,
    .wr_sel_b, .rd_strobe_b, .addr_b, .lanes_b, .din_b, .dout_b);
  // ============================================================
  // Tasks
  function automatic logic [71:0] rnd();
    return 72'({$urandom, $urandom, $urandom});
  endfunction
  task automatic check(string n, logic [71:0] s, logic [71:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic note(bit b, logic [71:0] e);
    if (b) qb.push_back(e);
    else qa.push_back(e);
    chk_a = !b;
    chk_b = b;
    @(posedge core_clk);
    #1;
    {chk_a, chk_b} = 2'h0;
  endtask
  task automatic go(bit b, logic w, logic [12:0] a, logic [7:0] l,
                    logic [71:0] d);
    logic rs;
    rs = !w && ram_mode == DPRC_MODE_RDWR;
    if (b) pb.drive(w, rs, a, l, d);
    else pa.drive(w, rs, a, l, d);
  endtask
  task automatic wr(bit b, logic [12:0] a, logic [7:0] l, logic [71:0] d);
    go(b, 1'h1, a, l, d);
    for (int i = 0; i < 8; i++) if (l[i]) mem[a][i*9 +: 9] = d[i*9 +: 9];
  endtask
  task automatic rd(bit b, logic [12:0] a);
    go(b, 1'h0, a, 8'($urandom), rnd());
    note(b, mem[a]);
  endtask
  // ============================================================
  // Clock, watchdog and result monitor
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (chk_a) check("dout_a", dout_a, qa.pop_front());
    if (chk_b) check("dout_b", dout_b, qb.pop_front());
    if (cyc == 8000) begin
      err_count++;
      test_done();
    end
  end
  // ============================================================
  // Scenarios
  initial begin
    logic [12:0] a;
    logic [71:0] lb;
    {core_clk, resetn, simple_dp, in_clk_sel, out_reg_en_a} = '0;
    {out_reg_en_b, clr_in_a, clr_out_a, clr_in_b, clr_out_b} = '0;
    {chk_a, chk_b} = 2'h0;
    {clk_en, ce_in_a, ce_out_a, ce_in_b, ce_out_b} = '1;
    ram_mode = DPRC_MODE_INDEP;
    {err_count, compares, cyc} = '0;
    void'($urandom(69193));
    repeat (8) @(posedge core_clk);
    #1;
    resetn = 1'h1;
    for (int i = 0; i < 4; i++) begin
      a = 13'($urandom);
      wr(i[0], a, 8'hFF, rnd());
      rd(1'b0, a);
      rd(1'b1, a);
    end
    lb = mem[a];
    // Lane masks from none to mixed, at the top address
    a = 13'h1FFF;
    wr(1'b0, a, 8'hFF, '0);
    for (int i = 0; i < 8; i++) begin
      wr(1'b1, a, (i == 0) ? 8'h00 : 8'($urandom), rnd());
      rd(1'b0, a);
    end
    // Enables low: write and read both dropped, then a global freeze
    {ce_in_a, ce_in_b} = 2'h0;
    go(1'b0, 1'h1, a, 8'hFF, ~mem[a]);
    go(1'b1, 1'h0, a, 8'hFF, rnd());
    note(1'b1, lb);
    {ce_in_a, ce_in_b} = 2'h3;
    clk_en = 1'h0;
    repeat (6) @(posedge core_clk);
    #1;
    clk_en = 1'h1;
    rd(1'b0, a);
    // Output register delays data by one fabric clock
    out_reg_en_a = 1'h1;
    wr(1'b1, a ^ 13'h1, 8'hFF, rnd());
    go(1'b0, 1'h0, a, 8'h00, rnd());
    go(1'b0, 1'h0, a ^ 13'h1, 8'h00, rnd());
    note(1'b0, mem[a]);
    // In/out clocks: clock A takes all inputs, clock B loads outputs
    ram_mode = DPRC_MODE_INOUT;
    ce_in_b = 1'h0;
    wr(1'b0, a ^ 13'h1, 8'hFF, rnd());
    go(1'b0, 1'h0, a ^ 13'h1, 8'h00, rnd());
    note(1'b0, mem[a]);
    go(1'b1, 1'h0, a, 8'h00, rnd());
    note(1'b0, mem[a ^ 13'h1]);
    // Read/write clocks: side A writes, side B reads by strobe
    ce_in_b = 1'h1;
    ram_mode = DPRC_MODE_RDWR;
    {ce_out_b, clr_out_b} = 2'h1;
    repeat (16) @(posedge core_clk);
    #1;
    for (int i = 0; i < 3; i++) begin
      a = 13'($urandom);
      wr(1'b0, a, 8'hFF, rnd());
      rd(1'b1, a);
    end
    go(1'b1, 1'h1, a, 8'hFF, ~mem[a]);
    rd(1'b1, a);
    clr_in_a = 1'h1;
    go(1'b0, 1'h1, a, 8'hFF, ~mem[a]);
    clr_in_a = 1'h0;
    rd(1'b1, a);
    out_reg_en_b = 1'h1;
    go(1'b1, 1'h0, a, 8'h00, rnd());
    go(1'b1, 1'h0, a ^ 13'h1, 8'h00, rnd());
    note(1'b1, mem[a]);
    clr_in_b = 1'h1;
    repeat (6) @(posedge core_clk);
    #1;
    note(1'b1, '0);
    clr_in_b = 1'h0;
    test_done();
  end
endmodule // tb_top
